// ### design/sss_pkg.sv
// shared constants and types for the supply supervisor sequencer
package sss_pkg;

  // ----------------------------------------------------------------
  // clock and printed times, each in its own unit
  // ----------------------------------------------------------------
  localparam longint unsigned SSS_CLK_MHZ     = 64'd200;
  localparam longint unsigned SSS_TEST_WIN_MS = 64'd1235;
  localparam longint unsigned SSS_DAY_HOURS   = 64'd24;
  localparam longint unsigned SSS_HOLD_MS     = 64'd145;
  localparam longint unsigned SSS_WDOG_MS     = 64'd1235;
  localparam longint unsigned SSS_ARM_US      = 64'd3;

  // ----------------------------------------------------------------
  // derived cycle counts (all exact at this rate)
  // ----------------------------------------------------------------
  localparam longint unsigned SSS_TEST_CYC_DEF =
    SSS_TEST_WIN_MS * SSS_CLK_MHZ * 64'd1000;
  localparam longint unsigned SSS_DAY_CYC_DEF =
    SSS_DAY_HOURS * 64'd3600 * 64'd1000000 * SSS_CLK_MHZ;
  localparam longint unsigned SSS_HOLD_CYC_DEF =
    SSS_HOLD_MS * SSS_CLK_MHZ * 64'd1000;
  localparam longint unsigned SSS_WDOG_CYC_DEF =
    SSS_WDOG_MS * SSS_CLK_MHZ * 64'd1000;
  localparam logic [15:0]     SSS_ARM_CYC =
    16'(SSS_ARM_US * SSS_CLK_MHZ);

  // ----------------------------------------------------------------
  // reset values of control state
  // ----------------------------------------------------------------
  localparam logic SSS_RESET_ACT_RST = 1'b1;
  localparam logic SSS_CELL_GOOD_RST = 1'b0;
  localparam logic SSS_SEAL_RST      = 1'b0;
  localparam logic SSS_WARN_N_RST    = 1'b1;
  localparam logic SSS_MAIN_LOW_RST  = 1'b1;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SSS_TEST_IDLE = 1'b0,
    SSS_TEST_RUN  = 1'b1
  } sss_test_t;

  typedef enum logic [1:0] {
    SSS_ARM_IDLE = 2'b00,
    SSS_ARM_HOLD = 2'b01,
    SSS_ARM_OUT  = 2'b10
  } sss_arm_t;

endpackage : sss_pkg

// ### design/sss_supply_supervisor_sequencer.sv
// sequencing logic of the supply supervisor: reset, cell test, seal

// ------------------------------------------------------------------
// ------------------------------------------------------------------
module sss_supply_supervisor_sequencer
  import sss_pkg::*;
#(
  parameter logic        RESET_ACTIVE_HIGH = 1'b0,
  parameter logic        HAS_WDOG_PULSE    = 1'b1,
  parameter logic        HAS_LOAD_PULSE    = 1'b1,
  parameter logic [31:0] TEST_CYC          = 32'(SSS_TEST_CYC_DEF),
  parameter logic [47:0] DAY_CYC           = 48'(SSS_DAY_CYC_DEF),
  parameter logic [31:0] HOLD_CYC          = 32'(SSS_HOLD_CYC_DEF),
  parameter logic [31:0] WDOG_CYC          = 32'(SSS_WDOG_CYC_DEF)
) (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic main_low_i,
  input  wire logic main_below_cell_i,
  input  wire logic cell_above_i,
  input  wire logic manual_reset_n_i,
  input  wire logic mr_above_arm_i,
  input  wire logic out_low_i,
  input  wire logic fail_sense_low_i,
  input  wire logic activity_in_i,
  output logic      reset_o,
  output logic      load_switch_o,
  output logic      load_test_pulse_o,
  output logic      cell_good_flag_o,
  output logic      on_backup_flag_o,
  output logic      cell_feed_o,
  output logic      seal_set_o,
  output logic      fail_warn_n_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        main_low;
    logic        main_low_d;
    logic        below_cell;
    logic        cell_ok;
    logic        mr_n;
    logic        mr_high;
    logic        out_low;
    logic        act;
    logic        act_prev;
    sss_test_t   test;
    logic [31:0] test_cnt;
    logic [47:0] day_cnt;
    logic        cell_good;
    logic        seal;
    sss_arm_t    arm;
    logic [15:0] arm_cnt;
    logic        rst_act;
    logic [31:0] hold_cnt;
    logic [31:0] wd_cnt;
    logic        wd_fire;
    logic        on_backup;
    logic        feed;
    logic        warn_n;
  } sss_state_t;

  sss_state_t st_reg;
  sss_state_t st_next;

  logic backup;
  logic pwr_up;
  logic cause;
  logic act_edge;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // comparator flags enter through one register stage
    st_next.main_low   = main_low_i;
    st_next.main_low_d = st_reg.main_low;
    st_next.below_cell = main_below_cell_i;
    st_next.cell_ok    = cell_above_i;
    st_next.mr_n       = manual_reset_n_i;
    st_next.mr_high    = mr_above_arm_i;
    st_next.out_low    = out_low_i;
    st_next.act        = activity_in_i;
    st_next.act_prev   = st_reg.act;

    // both conditions needed; a live supply never switches over
    backup   = st_reg.main_low & st_reg.below_cell;
    pwr_up   = st_reg.main_low_d & ~st_reg.main_low;
    act_edge = st_reg.act ^ st_reg.act_prev;
    cause    = st_reg.main_low | ~st_reg.mr_n
             | st_reg.wd_fire;

    st_next.on_backup = backup;
    st_next.feed      = st_reg.seal & backup;
    // not touched by the reset output logic or backup; srst loads it to 1
    st_next.warn_n    = ~fail_sense_low_i;

    // --------------------------------------------------------------
    // cell test schedule
    // --------------------------------------------------------------
    if (backup) begin
      st_next.test      = SSS_TEST_IDLE;
      st_next.test_cnt  = 32'h0;
      st_next.cell_good = 1'b0;
    end else if (pwr_up) begin
      st_next.test     = SSS_TEST_RUN;
      st_next.test_cnt = 32'h0;
      st_next.day_cnt  = 48'h0;
    end else begin
      case (st_reg.test)
        SSS_TEST_RUN: begin
          if (st_reg.test_cnt == TEST_CYC - 32'h1) begin
            st_next.test      = SSS_TEST_IDLE;
            st_next.test_cnt  = 32'h0;
            // the flag is taken on the last loaded cycle, so the cell
            // has settled under load for the whole window
            st_next.cell_good = st_reg.cell_ok;
          end else begin
            st_next.test_cnt = st_reg.test_cnt + 32'h1;
          end
        end
        SSS_TEST_IDLE: begin
          st_next.test_cnt = 32'h0;
        end
        default: begin
          st_next.test     = SSS_TEST_IDLE;
          st_next.test_cnt = 32'h0;
        end
      endcase
      if (!st_reg.main_low) begin
        if (st_reg.day_cnt == DAY_CYC - 48'h1) begin
          st_next.day_cnt  = 48'h0;
          st_next.test     = SSS_TEST_RUN;
          st_next.test_cnt = 32'h0;
        end else begin
          st_next.day_cnt = st_reg.day_cnt + 48'h1;
        end
      end
    end

    // --------------------------------------------------------------
    // freshness seal and its re-arm sequence
    // --------------------------------------------------------------
    if (pwr_up) begin
      st_next.seal = 1'b1;
      st_next.arm  = SSS_ARM_IDLE;
    end else begin
      case (st_reg.arm)
        SSS_ARM_IDLE: begin
          st_next.arm_cnt = 16'h0;
          if (st_reg.seal && backup && st_reg.mr_high) begin
            st_next.arm = SSS_ARM_HOLD;
          end
        end
        SSS_ARM_HOLD: begin
          if (!st_reg.mr_high || !backup) begin
            st_next.arm = SSS_ARM_IDLE;
          end else if (st_reg.arm_cnt == SSS_ARM_CYC - 16'h1) begin
            st_next.arm = SSS_ARM_OUT;
          end else begin
            st_next.arm_cnt = st_reg.arm_cnt + 16'h1;
          end
        end
        SSS_ARM_OUT: begin
          if (!st_reg.main_low) begin
            st_next.arm = SSS_ARM_IDLE;
          end else if (st_reg.out_low) begin
            st_next.seal = 1'b0;
            st_next.arm  = SSS_ARM_IDLE;
          end
        end
        default: begin
          st_next.arm = SSS_ARM_IDLE;
        end
      endcase
    end

    // --------------------------------------------------------------
    // reset output with hold time
    // --------------------------------------------------------------
    if (cause) begin
      st_next.rst_act  = 1'b1;
      st_next.hold_cnt = 32'h0;
    end else if (st_reg.rst_act) begin
      if (st_reg.hold_cnt == HOLD_CYC - 32'h1) begin
        st_next.rst_act = 1'b0;
      end else begin
        st_next.hold_cnt = st_reg.hold_cnt + 32'h1;
      end
    end

    // --------------------------------------------------------------
    // watchdog; a timeout only starts a fresh hold, it never latches
    // --------------------------------------------------------------
    st_next.wd_fire = 1'b0;
    if (!HAS_WDOG_PULSE || backup || st_reg.rst_act || act_edge) begin
      st_next.wd_cnt = 32'h0;
    end else if (st_reg.wd_cnt == WDOG_CYC - 32'h1) begin
      st_next.wd_cnt  = 32'h0;
      st_next.wd_fire = 1'b1;
    end else begin
      st_next.wd_cnt = st_reg.wd_cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_reg            <= '0;
      st_reg.main_low   <= SSS_MAIN_LOW_RST;
      st_reg.main_low_d <= SSS_MAIN_LOW_RST;
      st_reg.mr_n       <= 1'b1;
      st_reg.test       <= SSS_TEST_IDLE;
      st_reg.arm        <= SSS_ARM_IDLE;
      st_reg.cell_good  <= SSS_CELL_GOOD_RST;
      st_reg.seal       <= SSS_SEAL_RST;
      st_reg.rst_act    <= SSS_RESET_ACT_RST;
      st_reg.warn_n     <= SSS_WARN_N_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reset_o = RESET_ACTIVE_HIGH ? st_reg.rst_act
                                     : ~st_reg.rst_act;
  assign load_switch_o     = (st_reg.test == SSS_TEST_RUN);
  assign load_test_pulse_o = HAS_LOAD_PULSE
                           & (st_reg.test == SSS_TEST_RUN);
  assign cell_good_flag_o  = st_reg.cell_good;
  assign on_backup_flag_o  = st_reg.on_backup;
  assign cell_feed_o       = st_reg.feed;
  assign seal_set_o        = st_reg.seal;
  assign fail_warn_n_o     = st_reg.warn_n;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  property p_backup_cond;
    on_backup_flag_o |-> $past(st_reg.main_low) && $past(st_reg.below_cell);
  endproperty
  a_backup_cond: assert property (p_backup_cond)
    else $error("backup flag without both supply conditions");

  property p_no_backup_live;
    !st_reg.main_low |=> !on_backup_flag_o && !cell_feed_o;
  endproperty
  a_no_backup_live: assert property (p_no_backup_live)
    else $error("backup entered while supply above threshold");

  property p_backup_flag;
    (st_reg.main_low && st_reg.below_cell) |=> on_backup_flag_o;
  endproperty
  a_backup_flag: assert property (p_backup_flag)
    else $error("on-backup flag missing in backup mode");

  property p_backup_suspend;
    on_backup_flag_o |-> !load_switch_o && !cell_good_flag_o;
  endproperty
  a_backup_suspend: assert property (p_backup_suspend)
    else $error("test or cell-good active in backup mode");

  property p_pulse_window;
    load_test_pulse_o == (HAS_LOAD_PULSE && load_switch_o);
  endproperty
  a_pulse_window: assert property (p_pulse_window)
    else $error("load-test pulse differs from test window");

  property p_powerup_test;
    (pwr_up && !backup) |=> load_switch_o && st_reg.test_cnt == 32'h0;
  endproperty
  a_powerup_test: assert property (p_powerup_test)
    else $error("no test window after supply rise");

  property p_weak_cell;
    (load_switch_o && st_reg.test_cnt == TEST_CYC - 32'h1
      && !st_reg.cell_ok && !backup && !pwr_up)
      |=> !cell_good_flag_o && (!load_switch_o || st_reg.test_cnt == 32'h0);
  endproperty
  a_weak_cell: assert property (p_weak_cell)
    else $error("weak cell did not clear cell-good flag");

  property p_seal_set;
    pwr_up |=> seal_set_o;
  endproperty
  a_seal_set: assert property (p_seal_set)
    else $error("seal latch not set by supply rise");

  property p_feed;
    cell_feed_o |-> $past(st_reg.seal) && on_backup_flag_o;
  endproperty
  a_feed: assert property (p_feed)
    else $error("cell feeds output while sealed or off backup");

  sequence s_arm_hold;
    (st_reg.arm == SSS_ARM_HOLD) && st_reg.arm_cnt == SSS_ARM_CYC - 16'h1
      && st_reg.mr_high && backup;
  endsequence
  sequence s_arm_out;
    (st_reg.arm == SSS_ARM_OUT) && st_reg.out_low && st_reg.main_low;
  endsequence
  property p_rearm;
    s_arm_hold ##1 (s_arm_out and !pwr_up) |=> !seal_set_o;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("re-arm sequence did not clear seal latch");

  property p_reset_low;
    (st_reg.main_low || !st_reg.mr_n) |=> st_reg.rst_act;
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("reset not asserted for supply or manual cause");

  property p_reset_hold;
    $fell(st_reg.rst_act) |->
      $past(st_reg.hold_cnt) == HOLD_CYC - 32'h1 && !$past(cause);
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("reset released before the hold time");

  property p_polarity;
    reset_o == (RESET_ACTIVE_HIGH ? st_reg.rst_act : !st_reg.rst_act);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("reset output polarity wrong");

  property p_wdog_pulse;
    st_reg.wd_fire |=> st_reg.rst_act && st_reg.hold_cnt == 32'h0
      ##1 st_reg.wd_cnt == 32'h0;
  endproperty
  a_wdog_pulse: assert property (p_wdog_pulse)
    else $error("watchdog timeout gave no reset pulse");

  property p_warn;
    1'b1 |=> fail_warn_n_o == !$past(fail_sense_low_i);
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning output does not follow sense comparator");

endmodule : sss_supply_supervisor_sequencer

// ### verif/sss_host_model.sv
// processor-side model: reset input, activity strobe, warning interrupt
module sss_host_model (
  input  wire logic mclk_i,
  input  wire logic cpu_reset_n_i,
  input  wire logic warn_n_i,
  input  wire logic hang_i,
  output logic      activity_o,
  output logic      warn_seen_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] tick_reg = 3'h0;

  initial activity_o = 1'b0;
  initial warn_seen_o = 1'b0;

  // --------------------------------------------------------------
  // firmware loop
  // --------------------------------------------------------------
  // the loop only runs out of reset; a hung loop stops the strobe
  always @(posedge mclk_i) begin
    if (cpu_reset_n_i === 1'b1 && !hang_i) begin
      tick_reg <= tick_reg + 3'h1;
      if (tick_reg == 3'h7) begin
        activity_o <= ~activity_o;
      end
    end else begin
      tick_reg <= 3'h0;
    end
    if (warn_n_i === 1'b0) begin
      warn_seen_o <= 1'b1;
    end
  end
endmodule : sss_host_model

// ### verif/test_supply_supervisor_sequencer.sv
// self-checking bench of the supply supervisor sequencer
module test_supply_supervisor_sequencer;
  import sss_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // shortened counts keep the daily schedule inside a short run
  localparam int TC = 20;
  localparam int DC = 200;
  localparam int HC = 10;
  localparam int WC = 30;

  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic main_low_i = 1'b1;
  logic main_below_cell_i = 1'b0;
  logic cell_above_i = 1'b1;
  logic manual_reset_n_i = 1'b1;
  logic mr_above_arm_i = 1'b0;
  logic out_low_i = 1'b0;
  logic fail_sense_low_i = 1'b0;
  logic hang = 1'b0;
  logic activity_in_i;
  logic reset_o, load_switch_o, load_test_pulse_o, cell_good_flag_o;
  logic on_backup_flag_o, cell_feed_o, seal_set_o, fail_warn_n_o;
  logic warn_seen;
  logic reset_hi, pulse_hi;
  int   bad_count = 0;
  int   checks_done = 0;
  int   n;

  always #2.5 mclk_i = ~mclk_i;

  sss_supply_supervisor_sequencer #(
    .TEST_CYC(32'd20), .DAY_CYC(48'd200), .HOLD_CYC(32'd10),
    .WDOG_CYC(32'd30)
  ) i_sss_supply_supervisor_sequencer (
    .mclk_i(mclk_i), .srst_i(srst_i), .main_low_i(main_low_i),
    .main_below_cell_i(main_below_cell_i), .cell_above_i(cell_above_i),
    .manual_reset_n_i(manual_reset_n_i), .mr_above_arm_i(mr_above_arm_i),
    .out_low_i(out_low_i), .fail_sense_low_i(fail_sense_low_i),
    .activity_in_i(activity_in_i), .reset_o(reset_o),
    .load_switch_o(load_switch_o), .load_test_pulse_o(load_test_pulse_o),
    .cell_good_flag_o(cell_good_flag_o),
    .on_backup_flag_o(on_backup_flag_o), .cell_feed_o(cell_feed_o),
    .seal_set_o(seal_set_o), .fail_warn_n_o(fail_warn_n_o));

  // active-high variant without pulse pin or watchdog reset
  sss_supply_supervisor_sequencer #(
    .RESET_ACTIVE_HIGH(1'b1), .HAS_WDOG_PULSE(1'b0), .HAS_LOAD_PULSE(1'b0),
    .TEST_CYC(32'd20), .DAY_CYC(48'd200), .HOLD_CYC(32'd10),
    .WDOG_CYC(32'd30)
  ) i_sss_supply_supervisor_sequencer_hi (
    .mclk_i(mclk_i), .srst_i(srst_i), .main_low_i(main_low_i),
    .main_below_cell_i(main_below_cell_i), .cell_above_i(cell_above_i),
    .manual_reset_n_i(manual_reset_n_i), .mr_above_arm_i(mr_above_arm_i),
    .out_low_i(out_low_i), .fail_sense_low_i(fail_sense_low_i),
    .activity_in_i(activity_in_i), .reset_o(reset_hi),
    .load_switch_o(), .load_test_pulse_o(pulse_hi),
    .cell_good_flag_o(), .on_backup_flag_o(), .cell_feed_o(),
    .seal_set_o(), .fail_warn_n_o());

  sss_host_model i_sss_host_model (
    .mclk_i(mclk_i), .cpu_reset_n_i(reset_o), .warn_n_i(fail_warn_n_o),
    .hang_i(hang), .activity_o(activity_in_i), .warn_seen_o(warn_seen));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // counts edges until the chosen output shows lvl, 1000 at most
  task automatic wait_for(input logic sel_rst, input logic lvl,
                          output int cnt);
    cnt = 0;
    while ((sel_rst ? reset_o : load_switch_o) !== lvl && cnt < 1000) begin
      @(posedge mclk_i);
      #1;
      cnt++;
    end
    if (cnt >= 1000) begin
      bad_count++;
      $display("Error wait_for expected %0h seen %0h", lvl, ~lvl);
    end
  endtask : wait_for

  // entered in the time step of the edge that drove the cause away
  task automatic chk_release();
    repeat (HC) @(posedge mclk_i);
    #1;
    chk("reset held", reset_o, 1'b0);
    @(posedge mclk_i);
    #1;
    chk("reset freed", reset_o, 1'b1);
  endtask : chk_release

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_power_up();
    @(posedge mclk_i) main_low_i <= 1'b0;
    chk_release();
    chk("seal", seal_set_o, 1'b1);
    chk("load", load_switch_o, 1'b1);
    wait_for(1'b0, 1'b0, n);
    // window opens two edges after the change, reset frees after HC + 1
    chk("window tail", 32'(n), 32'(TC - HC + 1));
    chk("cell good", cell_good_flag_o, 1'b1);
  endtask : t_power_up

  task automatic t_daily();
    @(posedge mclk_i) cell_above_i <= 1'b0;
    #1;
    wait_for(1'b0, 1'b1, n);
    chk("pulse on", load_test_pulse_o, 1'b1);
    chk("pulse variant", pulse_hi, 1'b0);
    wait_for(1'b0, 1'b0, n);
    chk("window", 32'(n), 32'(TC));
    chk("pulse off", load_test_pulse_o, 1'b0);
    chk("weak cell", cell_good_flag_o, 1'b0);
    wait_for(1'b0, 1'b1, n);
    chk("day gap", 32'(n), 32'(DC - TC));
    @(posedge mclk_i) cell_above_i <= 1'b1;
    #1;
    wait_for(1'b0, 1'b0, n);
    chk("cell ok", cell_good_flag_o, 1'b1);
  endtask : t_daily

  task automatic t_backup_rearm();
    wait_for(1'b0, 1'b1, n);
    @(posedge mclk_i);
    main_low_i <= 1'b1;
    main_below_cell_i <= 1'b1;
    fail_sense_low_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    chk("backup", on_backup_flag_o, 1'b1);
    chk("feed", cell_feed_o, 1'b1);
    chk("abort", load_switch_o, 1'b0);
    chk("good low", cell_good_flag_o, 1'b0);
    chk("rst bk", reset_o, 1'b0);
    chk("warn bk", fail_warn_n_o, 1'b0);
    @(posedge mclk_i) mr_above_arm_i <= 1'b1;
    repeat (int'(SSS_ARM_CYC) + 4) @(posedge mclk_i);
    #1;
    chk("seal kept", seal_set_o, 1'b1);
    chk("no test", load_switch_o, 1'b0);
    @(posedge mclk_i) out_low_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    chk("seal clr", seal_set_o, 1'b0);
    @(posedge mclk_i);
    main_low_i <= 1'b0;
    main_below_cell_i <= 1'b0;
    mr_above_arm_i <= 1'b0;
    out_low_i <= 1'b0;
    fail_sense_low_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    chk("reseal", seal_set_o, 1'b1);
    chk("main", on_backup_flag_o, 1'b0);
    chk("new test", load_switch_o, 1'b1);
    repeat (HC) @(posedge mclk_i);
    #1;
    chk("rst free", reset_o, 1'b1);
  endtask : t_backup_rearm

  task automatic t_no_backup();
    @(posedge mclk_i) main_below_cell_i <= 1'b1;
    repeat (12) begin
      @(posedge mclk_i);
      #1;
      chk("no pulse", reset_o, 1'b1);
      chk("no bk", on_backup_flag_o, 1'b0);
    end
    @(posedge mclk_i);
    main_below_cell_i <= 1'b0;
    main_low_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    chk("low rst", reset_o, 1'b0);
    chk("low no bk", on_backup_flag_o, 1'b0);
    @(posedge mclk_i) main_low_i <= 1'b0;
    chk_release();
  endtask : t_no_backup

  task automatic t_manual();
    @(posedge mclk_i);
    manual_reset_n_i <= 1'b0;
    fail_sense_low_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk("warn", fail_warn_n_o, 1'b0);
    @(posedge mclk_i);
    #1;
    chk("mr rst", reset_o, 1'b0);
    chk("mr rst high", reset_hi, 1'b1);
    repeat (3 * HC) @(posedge mclk_i);
    #1;
    chk("mr hold", reset_o, 1'b0);
    @(posedge mclk_i);
    manual_reset_n_i <= 1'b1;
    fail_sense_low_i <= 1'b0;
    chk_release();
    chk("warn off", fail_warn_n_o, 1'b1);
    chk("free high", reset_hi, 1'b0);
    chk("irq", warn_seen, 1'b1);
  endtask : t_manual

  task automatic t_watchdog();
    @(posedge mclk_i) hang <= 1'b1;
    #1;
    wait_for(1'b1, 1'b0, n);
    chk("wd fire", 32'(n <= WC + 4), 32'h1);
    chk("no wd reset", reset_hi, 1'b0);
    wait_for(1'b1, 1'b1, n);
    chk("wd pulse", 32'(n >= HC && n <= HC + 2), 32'h1);
    wait_for(1'b1, 1'b0, n);
    chk("wd again", 32'(n >= WC && n <= WC + 4), 32'h1);
    @(posedge mclk_i) hang <= 1'b0;
    #1;
    wait_for(1'b1, 1'b1, n);
  endtask : t_watchdog

  // --------------------------------------------------------------
  // sequence and verdict
  // --------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_power_up();
    t_daily();
    t_backup_rearm();
    t_no_backup();
    t_manual();
    t_watchdog();
    tally_and_finish();
  end

  // the scenarios need about 1400 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule : test_supply_supervisor_sequencer
